// File: ingress_rate_pkg.sv
package ingress_rate_pkg;
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BCAST = 16'h1848;
  localparam logic [15:0] IDX_ADMIT = 16'h1849;
  localparam logic [15:0] IDX_CFG = 16'h184A;
  localparam logic [15:0] IDX_CMD = 16'h184B;
  localparam logic [15:0] IDX_STS = 16'h184C;
  localparam logic [15:0] IDX_WDATA = 16'h184D;
  localparam logic [15:0] IDX_RDATA = 16'h184E;
  localparam logic [15:0] ADDR_BCAST = {IDX_BCAST[13:0], 2'h0};
  localparam logic [15:0] ADDR_ADMIT = {IDX_ADMIT[13:0], 2'h0};
  localparam logic [15:0] ADDR_CFG = {IDX_CFG[13:0], 2'h0};
  localparam logic [15:0] ADDR_CMD = {IDX_CMD[13:0], 2'h0};
  localparam logic [15:0] ADDR_STS = {IDX_STS[13:0], 2'h0};
  localparam logic [15:0] ADDR_WDATA = {IDX_WDATA[13:0], 2'h0};
  localparam logic [15:0] ADDR_RDATA = {IDX_RDATA[13:0], 2'h0};
  // Broadcast throttle fields, port 0 only
  localparam int BT_EN_BIT = 8;
  localparam int BT_LVL_W = 8;
  localparam logic [7:0] BT_LVL_RST = 8'h02;
  localparam logic [5:0] BT_UNIT_PAD = 6'h00;
  localparam int BT_CNT_W = 14;
  // Admit field
  localparam int ADMIT_W = 3;
  localparam logic [2:0] ADMIT_RST = 3'h0;
  // Configuration fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam logic [1:0] MODE_PORT_PRIO = 2'h0;
  localparam logic [1:0] MODE_PORT = 2'h1;
  localparam logic [1:0] MODE_PRIO = 2'h2;
  // Command fields
  localparam int CMD_READ_BIT = 7;
  localparam int CMD_TYPE_LSB = 5;
  localparam int CMD_ADDR_W = 5;
  localparam logic [1:0] TYPE_RATE = 2'h1;
  localparam logic [1:0] TYPE_CBS = 2'h2;
  localparam logic [1:0] TYPE_EBS = 2'h3;
  // Metering table
  localparam int ENTRY_W = 16;
  localparam int TABLE_DEPTH = 26;
  localparam int RATE_COUNT = 24;
  localparam logic [4:0] RATE_LAST = 5'h17;
  localparam logic [4:0] ENTRY_CBS = 5'h18;
  localparam logic [4:0] ENTRY_EBS = 5'h19;
  localparam logic [15:0] RATE_RST = 16'h0014;
  localparam logic [15:0] BURST_RST = 16'h0600;
  localparam int RATE_STEP_NS = 20;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int THROTTLE_INTERVAL_NS = 1720000;
  localparam int THROTTLE_CYCLES = THROTTLE_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int INTERVAL_W = 24;
endpackage : ingress_rate_pkg

// File: rate_table.sv
`timescale 1ns/1ps
`default_nettype none
module rate_table (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic we_in,
  input wire logic re_in,
  input wire logic [4:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  typedef struct packed {
    logic [ingress_rate_pkg::TABLE_DEPTH-1:0][ingress_rate_pkg::ENTRY_W-1:0] mem;
    logic [ingress_rate_pkg::ENTRY_W-1:0] rdata;
  } table_state_t;

  table_state_t st_q;
  table_state_t st_d;
  logic in_range;

  // Addresses beyond the last entry neither store nor return data
  assign in_range = (addr_in <= ingress_rate_pkg::ENTRY_EBS);

  // Write and registered read
  always_comb begin
    st_d = st_q;
    if (we_in && in_range) begin
      st_d.mem[addr_in] = wdata_in;
    end
    if (re_in) begin
      st_d.rdata = in_range ? st_q.mem[addr_in] : 16'h0000;
    end
  end

  // Rate entries and burst entries start at their own defaults
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q.rdata <= 16'h0000;
      for (int i = 0; i < ingress_rate_pkg::TABLE_DEPTH; i++) begin
        st_q.mem[i] <= (i < ingress_rate_pkg::RATE_COUNT) ?
                       ingress_rate_pkg::RATE_RST : ingress_rate_pkg::BURST_RST;
      end
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
endmodule : rate_table
`default_nettype wire

// File: switch_ingress_rate_control.sv
// Summary of operation
// - Throttle enable bit limits accepted broadcast bytes on port 0.
// - Throttle level is bytes times 64 per 1.72 ms; resets to two.
// - Admit bits 2,1,0 let non-member packets in on ports 2,1,0.
// - Non-member admission still needs the destination VLAN active.
// - Mode 00 port and priority, 01 port only, 10 priority only.
// - Rate enable turns metering on; clear means no metering.
// - Each command register write made while pending is clear launches one indirect table access, unless its type is reserved or its address bad.
// - Command bit 7: one reads the table, zero writes it.
// - Type 01 rate entry, 10 committed burst, 11 excess burst.
// - Five-bit address picks one of 24 committed rate entries.
// - Port and priority mode: eight entries per port, priority 0 lowest.
// - Port only mode uses entries 0, 1, 2 for ports 0, 1, 2.
// - Priority only mode uses entry N for priority N up to 23.
// - Table holds 24 rate, one committed and one excess burst entries.
// - Pending is set during an access, clears itself, resets to zero.
// - Rate entry means per byte interval of value plus one times 20 ns.
`timescale 1ns/1ps
`default_nettype none
module switch_ingress_rate_control #(
  parameter int THROTTLE_CYCLES = ingress_rate_pkg::THROTTLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [15:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic bcast_byte_in,
  output logic bcast_block_out,
  input wire logic admit_req_in,
  input wire logic [1:0] admit_port_in,
  input wire logic vlan_member_in,
  input wire logic vlan_active_in,
  output logic admit_valid_out,
  output logic admit_ok_out,
  input wire logic meter_req_in,
  input wire logic [1:0] meter_port_in,
  input wire logic [4:0] meter_prio_in,
  output logic meter_enable_out,
  output logic [1:0] meter_mode_out,
  output logic rate_valid_out,
  output logic [4:0] meter_index_out,
  output logic [16:0] rate_interval_out
);
  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_ACCESS,
    CMD_CAPTURE
  } cmd_state_t;

  typedef struct packed {
    logic bt_en;
    logic [7:0] bt_level;
    logic [2:0] admit;
    logic rate_en;
    logic [1:0] rate_mode;
    logic cmd_read;
    logic [1:0] cmd_type;
    logic [4:0] cmd_addr;
    logic pending;
    logic [15:0] wdata;
    logic [15:0] rddata;
    cmd_state_t cmd_state;
    logic [31:0] bus_rdata;
    logic [ingress_rate_pkg::INTERVAL_W-1:0] interval;
    logic [13:0] bt_count;
    logic bt_block;
    logic admit_valid;
    logic admit_ok;
    logic lookup_pend;
    logic rate_valid;
    logic [4:0] meter_index;
    logic [16:0] rate_interval;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic mem_we;
  logic mem_re;
  logic [4:0] mem_addr;
  logic [15:0] mem_rdata;
  logic [4:0] cmd_entry;
  logic cmd_valid;
  logic [4:0] lookup_index;
  logic [13:0] bt_limit;

  localparam logic [23:0] INTERVAL_RELOAD = 24'(THROTTLE_CYCLES - 1);

  // Target entry of the stored command; reserved type or bad address is a no-op
  always_comb begin
    cmd_entry = st_q.cmd_addr;
    cmd_valid = 1'b0;
    case (st_q.cmd_type)
      ingress_rate_pkg::TYPE_RATE: begin
        cmd_valid = (st_q.cmd_addr <= ingress_rate_pkg::RATE_LAST);
      end
      ingress_rate_pkg::TYPE_CBS: begin
        cmd_entry = ingress_rate_pkg::ENTRY_CBS;
        cmd_valid = 1'b1;
      end
      ingress_rate_pkg::TYPE_EBS: begin
        cmd_entry = ingress_rate_pkg::ENTRY_EBS;
        cmd_valid = 1'b1;
      end
      default: begin
        cmd_valid = 1'b0;
      end
    endcase
  end

  // Rate entry used by the metering datapath for each mode
  always_comb begin
    case (st_q.rate_mode)
      ingress_rate_pkg::MODE_PORT_PRIO: begin
        lookup_index = {meter_port_in, meter_prio_in[2:0]};
      end
      ingress_rate_pkg::MODE_PORT: begin
        lookup_index = {3'h0, meter_port_in};
      end
      ingress_rate_pkg::MODE_PRIO: begin
        lookup_index = meter_prio_in;
      end
      default: begin
        lookup_index = 5'h00;
      end
    endcase
  end

  // Byte budget of the throttle window
  assign bt_limit = {st_q.bt_level, ingress_rate_pkg::BT_UNIT_PAD};

  // Table port: a command access wins, a lookup in that cycle is dropped
  always_comb begin
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_addr = lookup_index;
    if (st_q.cmd_state == CMD_ACCESS) begin
      mem_addr = cmd_entry;
      mem_we = cmd_valid && !st_q.cmd_read;
      mem_re = cmd_valid && st_q.cmd_read;
    end else if (meter_req_in && st_q.rate_en) begin
      mem_re = 1'b1;
    end
  end

  // Next state of registers, command engine and datapath
  always_comb begin
    st_d = st_q;
    st_d.bus_rdata = 32'h0000_0000;
    st_d.rate_valid = 1'b0;
    st_d.admit_valid = 1'b0;
    st_d.lookup_pend = 1'b0;
    // Register writes; only documented fields are stored
    if (wr_in) begin
      if (addr_in == ingress_rate_pkg::ADDR_BCAST) begin
        st_d.bt_en = wdata_in[ingress_rate_pkg::BT_EN_BIT];
        st_d.bt_level = wdata_in[7:0];
      end else if (addr_in == ingress_rate_pkg::ADDR_ADMIT) begin
        st_d.admit = wdata_in[2:0];
      end else if (addr_in == ingress_rate_pkg::ADDR_CFG) begin
        st_d.rate_en = wdata_in[ingress_rate_pkg::CFG_EN_BIT];
        st_d.rate_mode = wdata_in[2:1];
      end else if (addr_in == ingress_rate_pkg::ADDR_CMD) begin
        // A busy engine drops the new command whole
        if (!st_q.pending) begin
          st_d.cmd_read = wdata_in[ingress_rate_pkg::CMD_READ_BIT];
          st_d.cmd_type = wdata_in[6:5];
          st_d.cmd_addr = wdata_in[4:0];
          st_d.pending = 1'b1;
          st_d.cmd_state = CMD_ACCESS;
        end
      end else if (addr_in == ingress_rate_pkg::ADDR_WDATA) begin
        st_d.wdata = wdata_in[15:0];
      end
    end
    // Register reads; unmapped addresses answer zero
    if (rd_in) begin
      if (addr_in == ingress_rate_pkg::ADDR_BCAST) begin
        st_d.bus_rdata = {23'h000000, st_q.bt_en, st_q.bt_level};
      end else if (addr_in == ingress_rate_pkg::ADDR_ADMIT) begin
        st_d.bus_rdata = {29'h00000000, st_q.admit};
      end else if (addr_in == ingress_rate_pkg::ADDR_CFG) begin
        st_d.bus_rdata = {29'h00000000, st_q.rate_mode, st_q.rate_en};
      end else if (addr_in == ingress_rate_pkg::ADDR_CMD) begin
        st_d.bus_rdata = {24'h000000, st_q.cmd_read, st_q.cmd_type, st_q.cmd_addr};
      end else if (addr_in == ingress_rate_pkg::ADDR_STS) begin
        st_d.bus_rdata = {31'h00000000, st_q.pending};
      end else if (addr_in == ingress_rate_pkg::ADDR_WDATA) begin
        st_d.bus_rdata = {16'h0000, st_q.wdata};
      end else if (addr_in == ingress_rate_pkg::ADDR_RDATA) begin
        st_d.bus_rdata = {16'h0000, st_q.rddata};
      end
    end
    // Indirect access engine
    case (st_q.cmd_state)
      CMD_ACCESS: begin
        if (cmd_valid && st_q.cmd_read) begin
          st_d.cmd_state = CMD_CAPTURE;
        end else begin
          st_d.pending = 1'b0;
          st_d.cmd_state = CMD_IDLE;
        end
      end
      CMD_CAPTURE: begin
        st_d.rddata = mem_rdata;
        st_d.pending = 1'b0;
        st_d.cmd_state = CMD_IDLE;
      end
      default: begin
        // Idle must not undo a launch made above, or pending would stick
        if (st_q.cmd_state != CMD_IDLE) begin
          st_d.cmd_state = CMD_IDLE;
        end
      end
    endcase
    // Metering lookup result, one cycle after the table read
    if (st_q.cmd_state != CMD_ACCESS && meter_req_in && st_q.rate_en) begin
      st_d.lookup_pend = 1'b1;
      st_d.meter_index = lookup_index;
    end
    if (st_q.lookup_pend) begin
      st_d.rate_valid = 1'b1;
      st_d.rate_interval = {1'b0, mem_rdata} + 17'h00001;
    end
    // Throttle window; restarting the count each window bounds the rate
    if (st_q.interval == 24'h000000) begin
      st_d.interval = INTERVAL_RELOAD;
      st_d.bt_count = 14'h0000;
    end else begin
      st_d.interval = st_q.interval - 24'h000001;
      if (bcast_byte_in && st_q.bt_count < bt_limit) begin
        st_d.bt_count = st_q.bt_count + 14'h0001;
      end
    end
    st_d.bt_block = st_q.bt_en && (st_d.bt_count >= bt_limit);
    // Admission decision for one packet
    if (admit_req_in) begin
      st_d.admit_valid = 1'b1;
      st_d.admit_ok = vlan_active_in && (vlan_member_in ||
                      (admit_port_in != 2'h3 && st_q.admit[admit_port_in]));
    end
  end

  // Single state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
      st_q.bt_level <= ingress_rate_pkg::BT_LVL_RST;
      st_q.admit <= ingress_rate_pkg::ADMIT_RST;
      st_q.cmd_state <= CMD_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Metering table storage
  rate_table u_table (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .we_in(mem_we),
    .re_in(mem_re),
    .addr_in(mem_addr),
    .wdata_in(st_q.wdata),
    .rdata_out(mem_rdata)
  );

  // Outputs straight from the state register
  assign rdata_out = st_q.bus_rdata;
  assign bcast_block_out = st_q.bt_block;
  assign admit_valid_out = st_q.admit_valid;
  assign admit_ok_out = st_q.admit_ok;
  assign meter_enable_out = st_q.rate_en;
  assign meter_mode_out = st_q.rate_mode;
  assign rate_valid_out = st_q.rate_valid;
  assign meter_index_out = st_q.meter_index;
  assign rate_interval_out = st_q.rate_interval;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  logic cmd_wr;
  logic lookup_go;
  assign cmd_wr = wr_in && (addr_in == ingress_rate_pkg::ADDR_CMD);
  // Lookup that the table port accepts this cycle
  assign lookup_go = meter_req_in && st_q.rate_en && st_q.cmd_state != CMD_ACCESS;

  pending_set_a: assert property (cmd_wr && !st_q.pending |=> st_q.pending)
    else $error("command write did not raise pending");
  busy_ignore_a: assert property (cmd_wr && st_q.pending |=>
    $stable(st_q.cmd_addr) && $stable(st_q.cmd_type) && $stable(st_q.cmd_read))
    else $error("command accepted while pending");
  pending_clear_a: assert property ($rose(st_q.pending) |-> ##[1:2] !st_q.pending)
    else $error("pending did not clear");
  read_capture_a: assert property (st_q.cmd_state == CMD_CAPTURE |=>
    st_q.rddata == $past(mem_rdata))
    else $error("table read data not captured");
  throttle_off_a: assert property (bcast_block_out |-> $past(st_q.bt_en))
    else $error("broadcast blocked while throttle disabled");
  // The decision is held after the query, so only the valid cycle is judged
  admit_active_a: assert property (admit_valid_out && admit_ok_out |->
    $past(vlan_active_in))
    else $error("packet admitted to inactive vlan");
  admit_bit_a: assert property (admit_req_in && vlan_active_in &&
    admit_port_in == 2'h1 && st_q.admit[1] |=> admit_ok_out)
    else $error("non-member admit bit ignored");
  meter_off_a: assert property (rate_valid_out |-> $past(st_q.rate_en, 2))
    else $error("lookup while metering disabled");
  port_index_a: assert property (lookup_go && st_q.rate_mode ==
    ingress_rate_pkg::MODE_PORT |=> meter_index_out == {3'h0, $past(meter_port_in)})
    else $error("port only index wrong");
  rate_value_a: assert property (rate_valid_out |->
    rate_interval_out == {1'b0, $past(mem_rdata)} + 17'h00001)
    else $error("rate interval not value plus one");
  // Register fields, throttle window, table engine, lookups and admission, some from internal state
  mode_write_a: assert property (wr_in && addr_in == ingress_rate_pkg::ADDR_CFG |=>
    meter_mode_out == $past(wdata_in[2:1]) && meter_enable_out == $past(wdata_in[0]))
    else $error("rate configuration not stored");
  window_restart_a: assert property (st_q.interval == 24'h000000 |=>
    st_q.bt_count == 14'h0000)
    else $error("throttle window did not restart");
  write_done_a: assert property (st_q.cmd_state == CMD_ACCESS && !st_q.cmd_read |=>
    !st_q.pending)
    else $error("table write still pending");
  lookup_off_a: assert property (meter_req_in && !st_q.rate_en |=> !st_q.lookup_pend)
    else $error("lookup accepted while metering disabled");
  pair_index_a: assert property (lookup_go && st_q.rate_mode ==
    ingress_rate_pkg::MODE_PORT_PRIO |=> meter_index_out ==
    {$past(meter_port_in), $past(meter_prio_in[2:0])})
    else $error("port and priority index wrong");
  prio_index_a: assert property (lookup_go && st_q.rate_mode ==
    ingress_rate_pkg::MODE_PRIO |=> meter_index_out == $past(meter_prio_in))
    else $error("priority index wrong");
  admit_none_a: assert property (admit_req_in && admit_port_in == 2'h3 &&
    !vlan_member_in |=> !admit_ok_out)
    else $error("port without admit bit admitted");
  reserved_zero_a: assert property (rdata_out[31:17] == 15'h0000)
    else $error("reserved read bits not zero");

  read_cmd_c: cover property (cmd_wr && wdata_in[7] ##1 st_q.pending ##[1:2] !st_q.pending);
  write_cmd_c: cover property (cmd_wr && !wdata_in[7] && wdata_in[6:5] == 2'h2);
  throttle_c: cover property ($rose(bcast_block_out));
  admit_c: cover property (admit_req_in && !vlan_member_in && vlan_active_in ##1 admit_ok_out);
  refused_cmd_c: cover property (st_q.cmd_state == CMD_ACCESS && !cmd_valid);
endmodule : switch_ingress_rate_control
`default_nettype wire

// File: switch_ingress_rate_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module switch_ingress_rate_control_bench;
  // Short window so the throttle scenario stays brief
  localparam int TC = 200;
  localparam logic [15:0] A_BC = ingress_rate_pkg::ADDR_BCAST;
  localparam logic [15:0] A_AD = ingress_rate_pkg::ADDR_ADMIT;
  localparam logic [15:0] A_CF = ingress_rate_pkg::ADDR_CFG;
  localparam logic [15:0] A_CM = ingress_rate_pkg::ADDR_CMD;
  localparam logic [15:0] A_ST = ingress_rate_pkg::ADDR_STS;
  localparam logic [15:0] A_WD = ingress_rate_pkg::ADDR_WDATA;
  localparam logic [15:0] A_RD = ingress_rate_pkg::ADDR_RDATA;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [31:0] wdata_in = 32'h00000000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic bcast_byte_in = 1'b0;
  logic admit_req_in = 1'b0;
  logic [1:0] admit_port_in = 2'h0;
  logic vlan_member_in = 1'b0;
  logic vlan_active_in = 1'b0;
  logic meter_req_in = 1'b0;
  logic [1:0] meter_port_in = 2'h0;
  logic [4:0] meter_prio_in = 5'h00;
  logic [31:0] rdata_out;
  logic bcast_block_out;
  logic admit_valid_out;
  logic admit_ok_out;
  logic meter_enable_out;
  logic [1:0] meter_mode_out;
  logic rate_valid_out;
  logic [4:0] meter_index_out;
  logic [16:0] rate_interval_out;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] rv;
  int n;
  // Table targets {type, addr} and the values written to them
  logic [6:0] sel [5] = '{7'h29, 7'h22, 7'h37, 7'h40, 7'h60};
  logic [15:0] val [5] = '{16'h1234, 16'h0000, 16'hFFFF, 16'h0ABC, 16'h0DEF};
  // Admission cases {port, member, active, expected}
  logic [4:0] ac [5] = '{5'h0B, 5'h02, 5'h08, 5'h17, 5'h1A};

  // Free-running 10 MHz clock
  always #50 clk_in = ~clk_in;

  switch_ingress_rate_control #(.THROTTLE_CYCLES(TC)) dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .bcast_byte_in(bcast_byte_in),
    .bcast_block_out(bcast_block_out), .admit_req_in(admit_req_in),
    .admit_port_in(admit_port_in), .vlan_member_in(vlan_member_in),
    .vlan_active_in(vlan_active_in), .admit_valid_out(admit_valid_out),
    .admit_ok_out(admit_ok_out), .meter_req_in(meter_req_in), .meter_port_in(meter_port_in),
    .meter_prio_in(meter_prio_in), .meter_enable_out(meter_enable_out),
    .meter_mode_out(meter_mode_out), .rate_valid_out(rate_valid_out),
    .meter_index_out(meter_index_out), .rate_interval_out(rate_interval_out)
  );

  // Compare with case equality so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask : rd

  task automatic rc(input logic [15:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask : rc

  // Poll pending under a bound; a stuck flag counts as a mismatch
  task automatic idle();
    int k;
    k = 0;
    do begin
      rd(A_ST, rv);
      k++;
    end while (rv[0] !== 1'b0 && k < 8);
    chk(rv, 32'h0, "pending not cleared");
  endtask : idle

  task automatic tbl_wr(input logic [6:0] s, input logic [15:0] d);
    wr(A_WD, {16'h0000, d});
    wr(A_CM, {24'h000000, 1'b0, s});
    idle();
  endtask : tbl_wr

  task automatic tbl_rd(input logic [6:0] s, input logic [15:0] exp, input string msg);
    wr(A_CM, {24'h000000, 1'b1, s});
    idle();
    rc(A_RD, {16'h0000, exp}, msg);
  endtask : tbl_rd

  task automatic meter(input logic [1:0] p, input logic [4:0] q);
    @(posedge clk_in);
    meter_req_in <= 1'b1;
    meter_port_in <= p;
    meter_prio_in <= q;
    @(posedge clk_in);
    meter_req_in <= 1'b0;
    n = 0;
    while (rate_valid_out !== 1'b1 && n < 6) begin
      @(negedge clk_in);
      n++;
    end
  endtask : meter

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rc(A_BC, 32'h2, "throttle reset");
    rc(A_AD, 32'h0, "admit reset");
    rc(A_CF, 32'h0, "config reset");
    rc(A_ST, 32'h0, "pending reset");
    rc(16'h0000, 32'h0, "unmapped read");
    wr(A_AD, 32'hFFFFFFFF);
    rc(A_AD, 32'h7, "admit reserved");
    wr(A_CF, 32'hFFFFFFFF);
    rc(A_CF, 32'h7, "config reserved");
    wr(A_BC, 32'hFFFFFFFF);
    rc(A_BC, 32'h1FF, "throttle reserved");
    wr(A_CF, 32'h0);
    $display("registers test done");
    // Defaults of rate and burst entries
    tbl_rd(7'h20, 16'h0014, "rate default");
    tbl_rd(7'h37, 16'h0014, "last rate default");
    tbl_rd(7'h40, 16'h0600, "committed burst default");
    tbl_rd(7'h60, 16'h0600, "excess burst default");
    for (int i = 0; i < 5; i++) begin
      tbl_wr(sel[i], val[i]);
    end
    for (int i = 0; i < 5; i++) begin
      tbl_rd(sel[i], val[i], "table readback");
    end
    // Refused targets leave read data untouched
    tbl_rd(7'h38, 16'h0DEF, "rate address 24");
    tbl_rd(7'h05, 16'h0DEF, "reserved type");
    rc(A_CM, 32'h85, "command readback");
    // Second command while the first read is pending
    wr(A_WD, 32'h5555);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= A_CM;
    wdata_in <= 32'hA9;
    @(posedge clk_in);
    wdata_in <= 32'h29;
    @(posedge clk_in);
    wr_in <= 1'b0;
    idle();
    rc(A_CM, 32'hA9, "pending command overwritten");
    rc(A_RD, 32'h1234, "first read result");
    tbl_rd(7'h29, 16'h1234, "ignored write took effect");
    $display("table test done");
    // Lookup in each metering mode, upper priority bits ignored in mode 00
    wr(A_CF, 32'h1);
    meter(2'h1, 5'h19);
    chk({31'h0, meter_enable_out}, 32'h1, "meter enable");
    chk({30'h0, meter_mode_out}, 32'h0, "mode 00");
    chk({27'h0, meter_index_out}, 32'h9, "port prio index");
    chk({15'h0, rate_interval_out}, 32'h1235, "interval");
    wr(A_CF, 32'h3);
    meter(2'h2, 5'h07);
    chk({30'h0, meter_mode_out}, 32'h1, "mode 01");
    chk({27'h0, meter_index_out}, 32'h2, "port index");
    chk({15'h0, rate_interval_out}, 32'h1, "zero entry interval");
    wr(A_CF, 32'h5);
    meter(2'h0, 5'h17);
    chk({30'h0, meter_mode_out}, 32'h2, "mode 10");
    chk({27'h0, meter_index_out}, 32'h17, "prio index");
    chk({15'h0, rate_interval_out}, 32'h10000, "max interval");
    wr(A_CF, 32'h7);
    meter(2'h1, 5'h05);
    chk({30'h0, meter_mode_out}, 32'h3, "mode 11");
    chk({27'h0, meter_index_out}, 32'h0, "reserved mode index");
    chk({15'h0, rate_interval_out}, 32'h15, "entry 0 interval");
    wr(A_CF, 32'h4);
    meter(2'h0, 5'h01);
    chk({31'h0, rate_valid_out}, 32'h0, "lookup while disabled");
    $display("metering test done");
    // Admission decisions with only port 1 admitted
    wr(A_AD, 32'h2);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      admit_req_in <= 1'b1;
      admit_port_in <= ac[i][4:3];
      vlan_member_in <= ac[i][2];
      vlan_active_in <= ac[i][1];
      @(posedge clk_in);
      admit_req_in <= 1'b0;
      @(negedge clk_in);
      chk({31'h0, admit_valid_out}, 32'h1, "admit valid");
      chk({31'h0, admit_ok_out}, {31'h0, ac[i][0]}, "admit decision");
    end
    $display("admission test done");
    // Disabled throttle never blocks, even across a full window
    wr(A_BC, 32'h001);
    bcast_byte_in <= 1'b1;
    rv = 32'h0;
    repeat (TC + 50) begin
      @(negedge clk_in);
      rv[0] = rv[0] | bcast_block_out;
    end
    chk(rv, 32'h0, "blocked while disabled");
    // Level 1 allows 64 bytes per window; measure from a window restart
    wr(A_BC, 32'h101);
    n = 0;
    while (bcast_block_out !== 1'b1 && n < 2 * TC) begin
      @(negedge clk_in);
      n++;
    end
    while (bcast_block_out !== 1'b0 && n < 4 * TC) begin
      @(negedge clk_in);
      n++;
    end
    n = 0;
    while (bcast_block_out !== 1'b1 && n < TC) begin
      @(negedge clk_in);
      n++;
    end
    chk({31'h0, n >= 62 && n <= 67}, 32'h1, "bytes before block");
    bcast_byte_in <= 1'b0;
    $display("throttle test done");
    close_out();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(100 * 20000);
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : switch_ingress_rate_control_bench
`default_nettype wire
